//--- rtl/lmrs_defs.vh
// Contract
// - all command strobes low with both bank bits low captures address bits as mode word
// - mode write completes two clocks after the command
// - burst length comes from mode bits 2:0
// - burst order sequential or interleaved from mode bit 3
// - read latency from mode bits 6:4
// - mode bits 12:7 are a test field, reserved positions zero
// - burst lengths 2,4,8,16 order low column bits 0,1:0,2:0,3:0
// - sequential order increments low bits, wrapping modulo burst length
// - interleaved order xors start with an up-counter
// - length 16 interleaved from 1111 steps 15 down to 0
// - strobes low with bank1 high, bank0 low captures extended word
// - extended write takes two clocks, repeatable when banks idle
// - extended bits 2:0 pick refresh extent, bits 6:5 drive strength
// - external temperature refresh code in extended word is ignored
// - refresh extent selects full, half or quarter array
`ifndef LMRS_DEFS_VH
`define LMRS_DEFS_VH
`define LMRS_ADDR_W 13
`define LMRS_SETTLE_CYC 2
`define LMRS_BL_LSB 0
`define LMRS_BL_MSB 2
`define LMRS_BT_BIT 3
`define LMRS_CL_LSB 4
`define LMRS_CL_MSB 6
`define LMRS_TM_LSB 7
`define LMRS_TM_MSB 12
`define LMRS_PA_LSB 0
`define LMRS_PA_MSB 2
`define LMRS_TC_LSB 3
`define LMRS_TC_MSB 4
`define LMRS_DS_LSB 5
`define LMRS_DS_MSB 6
`define LMRS_MODE_RST 13'h0032
`define LMRS_EXT_RST 13'h0000
`define LMRS_BL_2 3'h1
`define LMRS_BL_4 3'h2
`define LMRS_BL_8 3'h3
`define LMRS_BL_16 3'h4
`define LMRS_PA_FULL 3'h0
`define LMRS_PA_HALF 3'h1
`define LMRS_PA_QUARTER 3'h2
`endif

//--- rtl/lmrs_mode_regs.v
`timescale 1ns/1ns
`include "lmrs_defs.vh"
module lmrs_mode_regs (
  input wire i_clk,
  input wire i_sys_rst,
  input wire i_ce,
  input wire i_cke,
  input wire i_cs_n,
  input wire i_ras_n,
  input wire i_cas_n,
  input wire i_we_n,
  input wire [12:0] i_addr,
  input wire [1:0] i_ba,
  input wire i_burst_start,
  input wire [3:0] i_burst_col,
  output reg o_busy,
  output reg [12:0] o_mode_word,
  output reg [12:0] o_ext_word,
  output reg [3:0] o_burst_len,
  output reg o_interleave,
  output reg [2:0] o_read_latency,
  output reg [5:0] o_test_mode,
  output reg [1:0] o_refresh_extent,
  output reg [1:0] o_drive_strength,
  output reg o_burst_valid,
  output reg [3:0] o_burst_col
);
  // pending words, applied after the settle time
  reg [12:0] mode_pend_q;
  reg [12:0] ext_pend_q;
  // separate due flags so a mode load and an extended load never drop each other
  reg mode_due_q;
  reg ext_due_q;
  localparam [1:0] SETTLE_M1 = `LMRS_SETTLE_CYC - 1;
  localparam [12:0] TC_KEEP = ~(13'h0003 << `LMRS_TC_LSB);
  reg [1:0] settle_q;
  reg [3:0] bcnt_q;
  reg [3:0] bstart_q;
  reg [3:0] bmask_q;
  reg binter_q;
  wire cmd_load;
  wire mode_hit;
  wire ext_hit;

  // burst length field decode to a low-bit mask
  function [3:0] bl_mask;
    input [2:0] code;
    begin
      case (code)
        `LMRS_BL_2: bl_mask = 4'h1;
        `LMRS_BL_4: bl_mask = 4'h3;
        `LMRS_BL_8: bl_mask = 4'h7;
        `LMRS_BL_16: bl_mask = 4'hf;
        default: bl_mask = 4'h0;
      endcase
    end
  endfunction

  // command decode
  assign cmd_load = i_cke & ~i_cs_n & ~i_ras_n & ~i_cas_n & ~i_we_n;
  assign mode_hit = cmd_load & (i_ba == 2'h0);
  assign ext_hit = cmd_load & (i_ba == 2'h2);

  // capture and two-clock completion
  always @(posedge i_clk) begin
    if (i_sys_rst) begin
      mode_pend_q <= `LMRS_MODE_RST;
      ext_pend_q <= `LMRS_EXT_RST;
      mode_due_q <= 1'b0;
      ext_due_q <= 1'b0;
      settle_q <= 2'h0;
      o_busy <= 1'b0;
      o_mode_word <= `LMRS_MODE_RST;
      o_ext_word <= `LMRS_EXT_RST;
    end else if (i_ce) begin
      if (mode_hit | ext_hit) begin
        if (mode_hit) begin
          mode_pend_q <= i_addr;
          mode_due_q <= 1'b1;
        end
        if (ext_hit) begin
          ext_pend_q <= i_addr & TC_KEEP;
          ext_due_q <= 1'b1;
        end
        settle_q <= SETTLE_M1;
        o_busy <= 1'b1;
      end else if (o_busy) begin
        if (settle_q != 2'h0) begin
          settle_q <= settle_q - 2'h1;
        end else begin
          o_busy <= 1'b0;
          mode_due_q <= 1'b0;
          ext_due_q <= 1'b0;
          if (mode_due_q)
            o_mode_word <= mode_pend_q;
          if (ext_due_q)
            o_ext_word <= ext_pend_q;
        end
      end
    end
  end

  // field decode of the applied words
  always @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_burst_len <= 4'h0;
      o_interleave <= 1'b0;
      o_read_latency <= 3'h0;
      o_test_mode <= 6'h00;
      o_refresh_extent <= 2'h0;
      o_drive_strength <= 2'h0;
    end else if (i_ce) begin
      // length minus one, so that a length of 16 fits in four bits
      o_burst_len <= bl_mask(o_mode_word[`LMRS_BL_MSB:`LMRS_BL_LSB]);
      o_interleave <= o_mode_word[`LMRS_BT_BIT];
      o_read_latency <= o_mode_word[`LMRS_CL_MSB:`LMRS_CL_LSB];
      o_test_mode <= o_mode_word[`LMRS_TM_MSB:`LMRS_TM_LSB];
      o_drive_strength <= o_ext_word[`LMRS_DS_MSB:`LMRS_DS_LSB];
      case (o_ext_word[`LMRS_PA_MSB:`LMRS_PA_LSB])
        `LMRS_PA_HALF: o_refresh_extent <= 2'h1;
        `LMRS_PA_QUARTER: o_refresh_extent <= 2'h2;
        default: o_refresh_extent <= 2'h0;
      endcase
    end
  end

  // burst column sequencer
  always @(posedge i_clk) begin
    if (i_sys_rst) begin
      bcnt_q <= 4'h0;
      bstart_q <= 4'h0;
      bmask_q <= 4'h0;
      binter_q <= 1'b0;
      o_burst_valid <= 1'b0;
      o_burst_col <= 4'h0;
    end else if (i_ce) begin
      if (i_burst_start && !o_busy) begin
        bmask_q <= bl_mask(o_mode_word[`LMRS_BL_MSB:`LMRS_BL_LSB]);
        binter_q <= o_mode_word[`LMRS_BT_BIT];
        bstart_q <= i_burst_col;
        bcnt_q <= 4'h1;
        o_burst_valid <= 1'b1;
        o_burst_col <= i_burst_col;
      end else if (o_burst_valid && ((bcnt_q & bmask_q) != 4'h0)) begin
        bcnt_q <= bcnt_q + 4'h1;
        if (binter_q)
          o_burst_col <= (bstart_q & ~bmask_q) | ((bstart_q ^ bcnt_q) & bmask_q);
        else
          o_burst_col <= (bstart_q & ~bmask_q) | ((bstart_q + bcnt_q) & bmask_q);
      end else begin
        o_burst_valid <= 1'b0;
      end
    end
  end
endmodule

//--- testbench/lmrs_ctl_model.sv
`timescale 1ns/1ns
module lmrs_ctl_model (
  input wire i_clk,
  output logic o_cke = 1'b1,
  output logic [3:0] o_cmd_n = 4'hf,
  output logic [12:0] o_addr = 13'h0,
  output logic [1:0] o_ba = 2'h0
);
  // one load cycle, then deselect with pins inverted, then settle
  task issue(input logic [1:0] ba, input logic [12:0] a);
    @(negedge i_clk);
    {o_cmd_n, o_ba, o_addr} <= {4'h0, ba, a};
    @(negedge i_clk);
    {o_cmd_n, o_ba, o_addr} <= {4'hf, ~ba, ~a};
    repeat (4) @(negedge i_clk);
  endtask
endmodule

//--- testbench/lmrs_mode_regs_checker.sv
`timescale 1ns/1ns
module lmrs_mode_regs_checker (
  input wire i_clk, i_sys_rst, i_ce, i_cke, i_cs_n, i_ras_n, i_cas_n, i_we_n,
  input wire o_busy, i_burst_start, o_burst_valid,
  input wire [12:0] i_addr, o_mode_word, o_ext_word,
  input wire [1:0] i_ba, o_drive_strength,
  input wire [2:0] o_read_latency,
  input wire [3:0] i_burst_col, o_burst_col
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);
  // all strobes low
  wire go = i_ce & i_cke & ~(i_cs_n | i_ras_n | i_cas_n | i_we_n);
  chk_busy_rise: assert property (go && !i_ba[0] |=> o_busy) else $error("busy");
  chk_mode_load: assert property ((go && i_ba == 2'h0) ##1 !go [*2]
    |=> o_mode_word == $past(i_addr, 3)) else $error("mode word");
  chk_ext_load: assert property ((go && i_ba == 2'h2) ##1 !go [*2]
    |=> o_ext_word == ($past(i_addr, 3) & 13'h1fe7)) else $error("ext word");
  chk_busy_len: assert property ($rose(o_busy) |=> o_busy ##1 !o_busy) else $error("len");
  chk_word_hold: assert property (!o_busy |=> $stable(o_mode_word) && $stable(o_ext_word))
    else $error("hold");
  chk_lat_field: assert property ($changed(o_mode_word) |=> o_read_latency == o_mode_word[6:4])
    else $error("latency");
  chk_drive_field: assert property ($changed(o_ext_word) |=> o_drive_strength == o_ext_word[6:5])
    else $error("drive");
  chk_burst_first: assert property (i_burst_start && !o_busy && !o_burst_valid
    |=> o_burst_valid && o_burst_col == $past(i_burst_col)) else $error("burst");
endmodule
bind lmrs_mode_regs lmrs_mode_regs_checker i_chk (.*);

//--- testbench/lmrs_mode_regs_tb.sv
`timescale 1ns/1ns
module lmrs_mode_regs_tb;
  logic i_clk = 0, i_sys_rst = 1, i_ce = 1, i_burst_start = 0, i_cke, o_busy, o_interleave;
  logic i_cs_n, i_ras_n, i_cas_n, i_we_n, o_burst_valid;
  logic [12:0] i_addr, o_mode_word, o_ext_word, a, m;
  logic [1:0] i_ba, o_refresh_extent, o_drive_strength;
  logic [3:0] i_burst_col = 0, o_burst_len, o_burst_col, s;
  logic [2:0] o_read_latency;
  logic [5:0] o_test_mode;
  int fails = 0, n_checks = 0, len, q[$];
  always #50 i_clk = ~i_clk;
  lmrs_mode_regs i_dut (.*);
  wire [3:0] cmd_n;
  assign {i_cs_n, i_ras_n, i_cas_n, i_we_n} = cmd_n;
  lmrs_ctl_model i_ctl (.i_clk, .o_cke(i_cke), .o_cmd_n(cmd_n), .o_addr(i_addr), .o_ba(i_ba));
  // compare and count
  task chk(input logic [12:0] got, exp);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task tally_and_finish;
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // every length and order, then refresh extents
  initial begin
    void'($urandom(32'hfe429370));
    repeat (4) @(negedge i_clk);
    i_sys_rst = 0;
    chk(o_mode_word, 13'h0032);
    for (int c = 1; c < 5; c++) for (int t = 0; t < 2; t++) begin
      a = {6'h0, 3'($urandom), 1'(t), 3'(c)};
      i_ctl.issue(2'h0, a);
      chk(o_mode_word, a);
      m = a;
      chk(o_interleave, 13'(t));
      chk(o_read_latency, a[6:4]);
      chk(o_test_mode, 13'h0);
      chk(o_burst_len, 13'((1 << c) - 1));
      chk(o_busy, 13'h0);
      len = 1 << c;
      s = 4'($urandom);
      if (c == 4 && t) s = 4'hf;
      q = {};
      for (int i = 0; i < len; i++) q.push_back(t ? s ^ i : (s & ~(len - 1)) | ((s + i) % len));
      i_burst_col = s;
      i_burst_start = 1;
      @(negedge i_clk);
      i_burst_start = 0;
      foreach (q[i]) begin
        chk({o_burst_valid, o_burst_col}, {1'b1, 4'(q[i])});
        @(negedge i_clk);
      end
      chk(o_burst_valid, 13'h0);
    end
    $display("test burst done");
    for (int p = 0; p < 3; p++) begin
      a = {6'h0, 2'($urandom), 2'h3, 3'(p)};
      i_ctl.issue(2'h2, a);
      chk(o_ext_word, a & 13'h1fe7);
      chk(o_refresh_extent, 13'(p));
      chk(o_drive_strength, a[6:5]);
    end
    i_ctl.issue(2'h1, 13'h1fff);
    chk(o_ext_word, a & 13'h1fe7);
    chk(o_mode_word, m);
    $display("test extended done");
    // clock enable low drops the command and freezes the words
    i_ce = 0;
    i_ctl.issue(2'h0, 13'h0013);
    i_ce = 1;
    chk(o_mode_word, m);
    // reset in mid-run restores the reset words
    i_sys_rst = 1;
    @(negedge i_clk);
    i_sys_rst = 0;
    chk(o_mode_word, 13'h0032);
    chk(o_ext_word, 13'h0);
    $display("test reset done");
    tally_and_finish;
  end
endmodule
